// file: cycle_timer.sv
// loadable down counter: busy for load_val cycles, done on the last
`timescale 1ns/1ps
`default_nettype none
module cycle_timer #(
  parameter int W = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  timer_if.cnt tmr
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // a new load always wins, so a rewrite restarts the count
  always_comb
  begin
    cnt_next = cnt_reg;
    if (tmr.load)
    begin
      cnt_next = tmr.load_val;
    end
    else if (cnt_reg != '0)
    begin
      cnt_next = cnt_reg - 1'h1;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_reg <= '0;
    end
    else
    begin
      cnt_reg <= cnt_next;
    end
  end

  assign tmr.busy = (cnt_reg != '0);
  assign tmr.done = (cnt_reg == W'(1));

endmodule
`default_nettype wire

// file: reset_pll_clock_sequencer.sv
// reset release, watchdog pulse, boot strap capture and clock ratio sequencing
`timescale 1ns/1ps
`default_nettype none
module reset_pll_clock_sequencer #(
  parameter int unsigned LOCK_CYCLES = reset_seq_pkg::LOCK_CYC_DEFAULT
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ext_reset_n_i,
  output logic ext_reset_n_o,
  output logic ext_reset_n_oe_o,
  input wire logic [reset_seq_pkg::BOOT_W-1:0] boot_mode_i,
  input wire logic pll_write_i,
  input wire logic [reset_seq_pkg::PLL_W-1:0] pll_value_i,
  input wire logic sys_div_write_i,
  input wire logic sys_div_half_i,
  input wire logic ext_cfg_write_i,
  input wire logic ext_timing_clock_div_i,
  input wire logic ext_clock_out_div_i,
  input wire logic wd_expire_i,
  output logic [reset_seq_pkg::PLL_W-1:0] sys_clk_num_o,
  output logic [reset_seq_pkg::DEN_W-1:0] sys_clk_den_o,
  output logic pll_locking_o,
  output logic ext_clock_out_o,
  output logic device_reset_o,
  output logic bus_valid_o,
  output logic [reset_seq_pkg::BOOT_W-1:0] boot_mode_o,
  output logic boot_valid_o
);
  import reset_seq_pkg::*;

  localparam int A_REL_DLY = RELEASE_CYC;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic ext_rst_meta_reg;
  logic ext_rst_sync_reg;
  logic [BOOT_W-1:0] boot_meta_reg;
  logic [BOOT_W-1:0] boot_sync_reg;

  // reset pin and straps come from the board, two flops each;
  // the supervisor holds reset long enough to pass them
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      ext_rst_meta_reg <= 1'h0;
      ext_rst_sync_reg <= 1'h0;
      boot_meta_reg <= BOOT_RST;
      boot_sync_reg <= BOOT_RST;
    end
    else
    begin
      ext_rst_meta_reg <= ext_reset_n_i;
      ext_rst_sync_reg <= ext_rst_meta_reg;
      boot_meta_reg <= boot_mode_i;
      boot_sync_reg <= boot_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  timer_if #(.W(LOCK_W)) lock_tmr ();
  timer_if #(.W(WD_W)) wd_tmr ();
  timer_if #(.W(REL_W)) rel_tmr ();

  cycle_timer #(.W(LOCK_W)) u_lock_timer (
    .core_clk_i (core_clk_i),
    .rst_n_i (rst_n_i),
    .tmr (lock_tmr)
  );

  cycle_timer #(.W(WD_W)) u_wd_timer (
    .core_clk_i (core_clk_i),
    .rst_n_i (rst_n_i),
    .tmr (wd_tmr)
  );

  cycle_timer #(.W(REL_W)) u_rel_timer (
    .core_clk_i (core_clk_i),
    .rst_n_i (rst_n_i),
    .tmr (rel_tmr)
  );

  // ----------------------------------------------------------------
  // watchdog reset pulse and device reset
  // ----------------------------------------------------------------
  logic wd_busy;
  logic dev_rst;
  logic dev_rst_reg;

  // a second expiry inside the pulse is ignored, the pulse is never stretched
  assign wd_busy = wd_tmr.busy;
  assign wd_tmr.load = wd_expire_i && !wd_busy;
  assign wd_tmr.load_val = WD_W'(WD_PULSE_CYC);
  assign ext_reset_n_o = 1'h0;
  assign ext_reset_n_oe_o = wd_busy;
  assign dev_rst = !ext_rst_sync_reg || wd_busy;

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      dev_rst_reg <= 1'h1;
    end
    else
    begin
      dev_rst_reg <= dev_rst;
    end
  end
  assign device_reset_o = dev_rst_reg;

  logic [WD_W-1:0] wd_len_reg;

  // helper: length of the current watchdog pulse
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      wd_len_reg <= '0;
    end
    else
    begin
      wd_len_reg <= wd_busy ? WD_W'(wd_len_reg + 1'h1) : '0;
    end
  end

  sequence s_wd_fire;
    wd_expire_i && !wd_busy;
  endsequence

  a_wd_pin_drive: assert property (s_wd_fire |=> (ext_reset_n_oe_o && dev_rst) [*8])
    else $error("watchdog pulse did not drive reset pin");
  a_wd_pulse_len: assert property ($fell(wd_busy) |-> wd_len_reg == WD_W'(WD_PULSE_CYC))
    else $error("watchdog pulse length wrong");

  // ----------------------------------------------------------------
  // clock mode, multiplier and output divider bits
  // ----------------------------------------------------------------
  clk_mode_t clk_mode_reg;
  clk_mode_t clk_mode_next;
  logic [PLL_W-1:0] pll_multiplier_reg;
  logic [PLL_W-1:0] pll_multiplier_next;
  logic ext_timing_clock_div_reg;
  logic ext_timing_clock_div_next;
  logic ext_clock_out_div_reg;
  logic ext_clock_out_div_next;
  logic [PLL_W-1:0] sys_num_next;
  logic [DEN_W-1:0] sys_den_next;
  logic [PLL_W-1:0] sys_num_reg;
  logic [DEN_W-1:0] sys_den_reg;

  // mode sequencing; writes during device reset are dropped
  always_comb
  begin
    clk_mode_next = clk_mode_reg;
    pll_multiplier_next = pll_multiplier_reg;
    ext_timing_clock_div_next = ext_timing_clock_div_reg;
    ext_clock_out_div_next = ext_clock_out_div_reg;
    lock_tmr.load = 1'h0;
    if (dev_rst)
    begin
      clk_mode_next = CM_QUARTER;
      pll_multiplier_next = MULT_RST;
      ext_timing_clock_div_next = EXT_DIV_RST;
      ext_clock_out_div_next = EXT_DIV_RST;
    end
    else
    begin
      if (ext_cfg_write_i)
      begin
        ext_timing_clock_div_next = ext_timing_clock_div_i;
        ext_clock_out_div_next = ext_clock_out_div_i;
      end
      if (pll_write_i)
      begin
        pll_multiplier_next = pll_value_i;
        if (pll_value_i == MULT_RST)
        begin
          clk_mode_next = CM_HALF;
        end
        else
        begin
          clk_mode_next = CM_LOCK;
          lock_tmr.load = 1'h1;
        end
      end
      else if (clk_mode_reg == CM_LOCK)
      begin
        if (lock_tmr.done)
        begin
          clk_mode_next = CM_PLL;
        end
      end
      else if (sys_div_write_i)
      begin
        // only the system divide moves, the output divider bits stay
        clk_mode_next = sys_div_half_i ? CM_HALF : CM_QUARTER;
      end
    end
  end
  assign lock_tmr.load_val = LOCK_W'(LOCK_CYCLES);

  // ratio follows the next mode so it lines up with the mode register
  always_comb
  begin
    case (clk_mode_next)
      CM_QUARTER:
      begin
        sys_num_next = QUARTER_NUM;
        sys_den_next = QUARTER_DEN;
      end
      CM_HALF, CM_LOCK:
      begin
        sys_num_next = HALF_NUM;
        sys_den_next = HALF_DEN;
      end
      CM_PLL:
      begin
        sys_num_next = pll_multiplier_next;
        sys_den_next = PLL_DEN;
      end
      default:
      begin
        sys_num_next = QUARTER_NUM;
        sys_den_next = QUARTER_DEN;
      end
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      clk_mode_reg <= CM_QUARTER;
      pll_multiplier_reg <= MULT_RST;
      ext_timing_clock_div_reg <= EXT_DIV_RST;
      ext_clock_out_div_reg <= EXT_DIV_RST;
      sys_num_reg <= QUARTER_NUM;
      sys_den_reg <= QUARTER_DEN;
    end
    else
    begin
      clk_mode_reg <= clk_mode_next;
      pll_multiplier_reg <= pll_multiplier_next;
      ext_timing_clock_div_reg <= ext_timing_clock_div_next;
      ext_clock_out_div_reg <= ext_clock_out_div_next;
      sys_num_reg <= sys_num_next;
      sys_den_reg <= sys_den_next;
    end
  end
  assign sys_clk_num_o = sys_num_reg;
  assign sys_clk_den_o = sys_den_reg;
  assign pll_locking_o = (clk_mode_reg == CM_LOCK);

  logic [LOCK_W-1:0] lock_len_reg;

  // helper: cycles spent locking since the last multiplier write
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      lock_len_reg <= '0;
    end
    else if (pll_write_i)
    begin
      lock_len_reg <= '0;
    end
    else if (pll_locking_o)
    begin
      lock_len_reg <= LOCK_W'(lock_len_reg + 1'h1);
    end
  end

  a_reset_quarter: assert property (dev_rst |=> sys_clk_num_o == QUARTER_NUM
      && sys_clk_den_o == QUARTER_DEN && ext_timing_clock_div_reg && ext_clock_out_div_reg)
    else $error("reset did not restore quarter rate and divider bits");
  a_lock_start: assert property (pll_write_i && !dev_rst && pll_value_i != MULT_RST
      |=> pll_locking_o && pll_multiplier_reg == $past(pll_value_i))
    else $error("multiplier write did not start lock phase");
  a_lock_half: assert property (pll_locking_o |-> sys_clk_num_o == HALF_NUM
      && sys_clk_den_o == HALF_DEN)
    else $error("system clock not at half rate while locking");
  a_lock_length: assert property ($fell(pll_locking_o) && clk_mode_reg == CM_PLL
      |-> lock_len_reg == LOCK_W'(LOCK_CYCLES))
    else $error("lock phase length wrong");
  a_lock_restart: assert property (pll_locking_o && pll_write_i && pll_value_i != MULT_RST
      && !dev_rst |=> pll_locking_o && lock_len_reg == '0)
    else $error("rewrite during lock did not restart the count");
  a_pll_ratio: assert property (clk_mode_reg == CM_PLL |-> sys_clk_num_o == pll_multiplier_reg
      && sys_clk_den_o == PLL_DEN)
    else $error("pll ratio wrong");
  a_fw_half_keep: assert property (sys_div_write_i && sys_div_half_i && !dev_rst && !pll_write_i
      && !pll_locking_o && !ext_cfg_write_i |=> clk_mode_reg == CM_HALF
      && $stable(ext_timing_clock_div_reg))
    else $error("half rate change disturbed timing divider");

  // ----------------------------------------------------------------
  // clock output pin: fractional divider of the oscillator
  // ----------------------------------------------------------------
  logic [EXT_DEN_W-1:0] ext_den;
  logic [ACC_W-1:0] nco_step;
  logic [ACC_W-1:0] nco_sum;
  logic [EXT_DEN_W-1:0] nco_acc_reg;
  logic [EXT_DEN_W-1:0] nco_acc_next;
  logic ext_clk_reg;
  logic ext_clk_next;

  // pin rate = system rate / 2^(bit count); rates above half the
  // oscillator cannot be shown and saturate at toggling every cycle;
  // the bit count is summed at two bits, a one-bit sum would wrap to zero
  always_comb
  begin
    ext_den = EXT_DEN_W'(EXT_DEN_W'(sys_den_reg)
        << (2'(ext_timing_clock_div_reg) + 2'(ext_clock_out_div_reg)));
    nco_step = ACC_W'({sys_num_reg, 1'h0});
    nco_sum = ACC_W'(nco_acc_reg) + nco_step;
    nco_acc_next = EXT_DEN_W'(nco_sum);
    ext_clk_next = ext_clk_reg;
    if (dev_rst)
    begin
      nco_acc_next = '0;
      ext_clk_next = 1'h0;
    end
    else if (nco_step >= ACC_W'(ext_den))
    begin
      nco_acc_next = '0;
      ext_clk_next = !ext_clk_reg;
    end
    else if (nco_sum >= ACC_W'(ext_den))
    begin
      nco_acc_next = EXT_DEN_W'(nco_sum - ACC_W'(ext_den));
      ext_clk_next = !ext_clk_reg;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      nco_acc_reg <= '0;
      ext_clk_reg <= 1'h0;
    end
    else
    begin
      nco_acc_reg <= nco_acc_next;
      ext_clk_reg <= ext_clk_next;
    end
  end
  assign ext_clock_out_o = ext_clk_reg;

  a_ext_div16: assert property (clk_mode_reg == CM_QUARTER && ext_timing_clock_div_reg
      && ext_clock_out_div_reg |-> ext_den == 5'h10)
    else $error("clock out not at oscillator over sixteen");

  // ----------------------------------------------------------------
  // reset release, bus valid and boot strap capture
  // ----------------------------------------------------------------
  rel_state_t rel_state_reg;
  rel_state_t rel_state_next;
  logic bus_valid_reg;
  logic bus_valid_next;
  logic [BOOT_W-1:0] boot_mode_reg;
  logic [BOOT_W-1:0] boot_mode_next;
  logic boot_valid_reg;
  logic boot_valid_next;

  // straps are caught at the valid point, well inside their hold window
  always_comb
  begin
    rel_state_next = rel_state_reg;
    bus_valid_next = bus_valid_reg;
    boot_mode_next = boot_mode_reg;
    boot_valid_next = boot_valid_reg;
    rel_tmr.load = 1'h0;
    if (dev_rst)
    begin
      rel_state_next = RS_RESET;
      bus_valid_next = 1'h0;
      boot_valid_next = 1'h0;
    end
    else
    begin
      case (rel_state_reg)
        RS_RESET:
        begin
          rel_tmr.load = 1'h1;
          rel_state_next = RS_WAIT;
        end
        RS_WAIT:
        begin
          if (rel_tmr.done)
          begin
            rel_state_next = RS_RUN;
            bus_valid_next = 1'h1;
            boot_mode_next = boot_sync_reg;
            boot_valid_next = 1'h1;
          end
        end
        RS_RUN:
        begin
          rel_state_next = RS_RUN;
        end
        default:
        begin
          rel_state_next = RS_RESET;
        end
      endcase
    end
  end
  assign rel_tmr.load_val = REL_W'(RELEASE_CYC - 1);

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      rel_state_reg <= RS_RESET;
      bus_valid_reg <= 1'h0;
      boot_mode_reg <= BOOT_RST;
      boot_valid_reg <= 1'h0;
    end
    else
    begin
      rel_state_reg <= rel_state_next;
      bus_valid_reg <= bus_valid_next;
      boot_mode_reg <= boot_mode_next;
      boot_valid_reg <= boot_valid_next;
    end
  end
  assign bus_valid_o = bus_valid_reg;
  assign boot_mode_o = boot_mode_reg;
  assign boot_valid_o = boot_valid_reg;

  logic [REL_W:0] rel_len_reg;

  // helper: cycles since the device reset last released
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || dev_rst)
    begin
      rel_len_reg <= '0;
    end
    else if (rel_len_reg != '1)
    begin
      rel_len_reg <= (REL_W + 1)'(rel_len_reg + 1'h1);
    end
  end

  sequence s_release;
    $fell(dev_rst);
  endsequence

  sequence s_quiet;
    !bus_valid_o [*8];
  endsequence

  a_rel_quiet: assert property (s_release |-> s_quiet)
    else $error("bus valid too early after release");
  a_rel_delay: assert property ($rose(bus_valid_o) |-> rel_len_reg == A_REL_DLY)
    else $error("bus valid not at release delay");
  a_boot_capture: assert property ($rose(boot_valid_o) |-> boot_mode_o == $past(boot_sync_reg))
    else $error("boot mode not captured from synchronised pins");

endmodule
`default_nettype wire

// file: reset_seq_pkg.sv
// shared constants and types for the reset and clock bring-up sequencer
//
// Overview of operation
// - power-up system clock runs at oscillator quarter
// - both clock-out divider bits reset to one
// - firmware half-rate change keeps timing divider bit
// - boot-mode pins sampled after reset release
// - multiplier write starts lock, then new frequency; a zero write goes straight to half rate with no lock
// - system clock stays oscillator half while locking
// - lock phase lasts 131072 oscillator cycles
// - system clock equals oscillator times half multiplier
// - watchdog reset pulse lasts 512 oscillator cycles
// - outputs valid 32 cycles after reset release
package reset_seq_pkg;

  // ----------------------------------------------------------------
  // clock periods in ns, and times in oscillator cycles as printed
  // ----------------------------------------------------------------
  localparam int OSC_PERIOD_NS = 10;
  localparam int CORE_PERIOD_NS = 10;
  localparam int LOCK_TIME_OSC = 131072;
  localparam int WD_PULSE_OSC = 512;
  localparam int RELEASE_OSC = 32;
  localparam int BOOT_HOLD_OSC = 200;
  localparam int EXT_RST_MIN_OSC = 8;

  // derived cycle counts at the core clock rate
  localparam int LOCK_CYC_DEFAULT = LOCK_TIME_OSC * OSC_PERIOD_NS / CORE_PERIOD_NS;
  localparam int WD_PULSE_CYC = WD_PULSE_OSC * OSC_PERIOD_NS / CORE_PERIOD_NS;
  localparam int RELEASE_CYC = RELEASE_OSC * OSC_PERIOD_NS / CORE_PERIOD_NS;
  localparam int BOOT_HOLD_CYC = BOOT_HOLD_OSC * OSC_PERIOD_NS / CORE_PERIOD_NS;
  localparam int EXT_RST_MIN_CYC = EXT_RST_MIN_OSC * OSC_PERIOD_NS / CORE_PERIOD_NS;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int BOOT_W = 4;
  localparam int PLL_W = 4;
  localparam int DEN_W = 3;
  localparam int EXT_DEN_W = 5;
  localparam int ACC_W = 6;
  localparam int LOCK_W = 18;
  localparam int WD_W = 10;
  localparam int REL_W = 6;

  // ----------------------------------------------------------------
  // reset values and clock ratios (num / den of oscillator)
  // ----------------------------------------------------------------
  localparam logic EXT_DIV_RST = 1'h1;
  localparam logic [PLL_W-1:0] MULT_RST = 4'h0;
  localparam logic [PLL_W-1:0] QUARTER_NUM = 4'h1;
  localparam logic [DEN_W-1:0] QUARTER_DEN = 3'h4;
  localparam logic [PLL_W-1:0] HALF_NUM = 4'h1;
  localparam logic [DEN_W-1:0] HALF_DEN = 3'h2;
  localparam logic [DEN_W-1:0] PLL_DEN = 3'h2;
  localparam logic [BOOT_W-1:0] BOOT_RST = 4'h0;

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CM_QUARTER = 2'b00,
    CM_HALF = 2'b01,
    CM_LOCK = 2'b10,
    CM_PLL = 2'b11
  } clk_mode_t;

  typedef enum logic [1:0] {
    RS_RESET = 2'b00,
    RS_WAIT = 2'b01,
    RS_RUN = 2'b10
  } rel_state_t;

endpackage

// file: reset_supervisor.sv
// board reset supervisor model: open-drain reset pin with pull-up, boot straps
`timescale 1ns/1ps
`default_nettype none
module reset_supervisor #(
  parameter int LOW_CYC = 8,
  parameter int HOLD_CYC = 200
) (
  input wire logic core_clk_i,
  input wire logic req_i,
  input wire logic [3:0] strap_i,
  input wire logic dev_oe_i,
  input wire logic dev_drv_i,
  output logic pin_o,
  output logic [3:0] boot_o
);
  int low_cnt = 0;
  int hold_cnt = 0;
  logic [3:0] strap_reg = 4'h0;
  logic flip = 1'b0;
  // --------------------------------------------------------------
  // pin level: any party pulling low wins, otherwise the pull-up
  // --------------------------------------------------------------
  assign pin_o = !((dev_oe_i && !dev_drv_i) || low_cnt > 0);
  // straps released after the hold: a moving pattern, not the old value
  assign boot_o = hold_cnt > 0 ? strap_reg : ~strap_reg ^ {3'h0, flip};
  // reset request keeps the pin low LOW_CYC cycles past its end
  always @(posedge core_clk_i)
  begin
    flip <= !flip;
    if (req_i)
    begin
      low_cnt <= LOW_CYC;
      strap_reg <= strap_i;
      hold_cnt <= LOW_CYC + HOLD_CYC;
    end
    else
    begin
      low_cnt <= low_cnt > 0 ? low_cnt - 1 : 0;
      hold_cnt <= hold_cnt > 0 ? hold_cnt - 1 : 0;
    end
  end
endmodule
`default_nettype wire

// file: tb_reset_pll_clock_sequencer.sv
// self-checking bench for the reset and clock bring-up sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_reset_pll_clock_sequencer;
  import reset_seq_pkg::*;
  localparam int LC = 40;
  typedef struct {int kind; logic [3:0] val; logic [3:0] num; logic [2:0] den; int half;} row_t;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req = 1'b1;
  logic [3:0] strap = 4'hA;
  logic pin;
  logic [3:0] boot;
  logic ext_reset_n_o, ext_reset_n_oe_o, pll_locking_o, ext_clock_out_o;
  logic device_reset_o, bus_valid_o, boot_valid_o;
  logic pll_write_i = 1'b0, sys_div_write_i = 1'b0, sys_div_half_i = 1'b0;
  logic ext_cfg_write_i = 1'b0, ext_timing_clock_div_i = 1'b0, ext_clock_out_div_i = 1'b0;
  logic wd_expire_i = 1'b0;
  logic [3:0] pll_value_i = 4'h0;
  logic [3:0] sys_clk_num_o, boot_mode_o;
  logic [2:0] sys_clk_den_o;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  // kind 0 divider write, 1 multiplier write, 2 clock-out config write
  row_t rows [8] = '{
    '{0, 4'h1, 4'h1, 3'h2, 4},
    '{0, 4'h0, 4'h1, 3'h4, 8},
    '{2, 4'h1, 4'h1, 3'h4, 4},
    '{2, 4'h3, 4'h1, 3'h4, 8},
    '{1, 4'h4, 4'h4, 3'h2, 1},
    '{1, 4'h8, 4'h8, 3'h2, 1},
    '{1, 4'h0, 4'h1, 3'h2, 4},
    '{0, 4'h0, 4'h1, 3'h4, 8}};

  always #5 core_clk_i = !core_clk_i;

  reset_supervisor sup_u (.core_clk_i(core_clk_i), .req_i(req), .strap_i(strap),
    .dev_oe_i(ext_reset_n_oe_o), .dev_drv_i(ext_reset_n_o), .pin_o(pin), .boot_o(boot));

  reset_pll_clock_sequencer #(.LOCK_CYCLES(LC)) dut_u (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .ext_reset_n_i(pin), .ext_reset_n_o(ext_reset_n_o),
    .ext_reset_n_oe_o(ext_reset_n_oe_o), .boot_mode_i(boot), .pll_write_i(pll_write_i),
    .pll_value_i(pll_value_i), .sys_div_write_i(sys_div_write_i),
    .sys_div_half_i(sys_div_half_i), .ext_cfg_write_i(ext_cfg_write_i),
    .ext_timing_clock_div_i(ext_timing_clock_div_i),
    .ext_clock_out_div_i(ext_clock_out_div_i), .wd_expire_i(wd_expire_i),
    .sys_clk_num_o(sys_clk_num_o), .sys_clk_den_o(sys_clk_den_o),
    .pll_locking_o(pll_locking_o), .ext_clock_out_o(ext_clock_out_o),
    .device_reset_o(device_reset_o), .bus_valid_o(bus_valid_o),
    .boot_mode_o(boot_mode_o), .boot_valid_o(boot_valid_o));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input bit ok, input string msg);
    compares++;
    if (!ok)
    begin
      n_errors++;
      $display("BAD t=%0t %s", $time, msg);
    end
  endtask

  task automatic final_report();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // write strobes are one cycle wide, raised and dropped at falling edges
  task automatic issue(input int kind, input logic [3:0] val);
    @(negedge core_clk_i);
    pll_write_i = (kind == 1);
    sys_div_write_i = (kind == 0);
    ext_cfg_write_i = (kind == 2);
    pll_value_i = val;
    sys_div_half_i = val[0];
    ext_timing_clock_div_i = val[1];
    ext_clock_out_div_i = val[0];
    @(negedge core_clk_i);
    pll_write_i = 1'b0;
    sys_div_write_i = 1'b0;
    ext_cfg_write_i = 1'b0;
  endtask

  // counts edges a level stays high; optionally strobes again mid-way
  task automatic count_high(input int which, input int at, output int cnt);
    cnt = 0;
    while ((which == 0 ? pll_locking_o : ext_reset_n_oe_o) === 1'b1 && cnt < 2000)
    begin
      @(negedge core_clk_i);
      if (which == 0)
        pll_write_i = (cnt == at);
      else
        wd_expire_i = (cnt == at);
      @(posedge core_clk_i);
      #1;
      cnt++;
    end
  endtask

  // half period of the clock output; the accumulator keeps its phase over a
  // ratio change, so the first two toggles may come early and are skipped
  task automatic measure_half(output int cnt);
    logic v;
    v = ext_clock_out_o;
    cnt = 0;
    for (int k = 0; k < 3; k++)
    begin
      cnt = 0;
      while (ext_clock_out_o === v && cnt < 50)
      begin
        @(posedge core_clk_i);
        #1;
        cnt++;
      end
      v = ext_clock_out_o;
    end
  endtask

  // edges from device reset release until the bus becomes valid
  task automatic wait_release(input bit chk_boot, input logic [3:0] exp);
    int cnt;
    cnt = 0;
    // a warm reset reaches device_reset_o only after the pin synchronisers
    while (device_reset_o !== 1'b1 && cnt < 100)
    begin
      @(posedge core_clk_i);
      #1;
      cnt++;
    end
    cnt = 0;
    while (device_reset_o !== 1'b0 && cnt < 1000)
    begin
      @(posedge core_clk_i);
      #1;
      cnt++;
    end
    cnt = 0;
    while (bus_valid_o !== 1'b1 && cnt < 100)
    begin
      @(posedge core_clk_i);
      #1;
      cnt++;
    end
    // device_reset_o is registered, so it falls one edge after the release
    chk(cnt + 1 == RELEASE_CYC && boot_valid_o === 1'b1, "release delay");
    if (chk_boot)
      chk(boot_mode_o === exp, "boot straps");
  endtask

  // hang guard: the whole run needs about a thousand cycles
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      final_report();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (20) @(negedge core_clk_i);
    chk(sys_clk_num_o === QUARTER_NUM && sys_clk_den_o === QUARTER_DEN, "reset ratio");
    rst_n_i = 1'b1;
    req = 1'b0;
    wait_release(1'b1, 4'hA);
    measure_half(n);
    chk(n == 8, "clock out at power-up");
    $display("test power_up done");
    foreach (rows[i])
    begin
      issue(rows[i].kind, rows[i].val);
      @(posedge core_clk_i);
      #1;
      if (rows[i].kind == 1 && rows[i].val != 4'h0)
      begin
        chk(pll_locking_o === 1'b1 && sys_clk_num_o === HALF_NUM && sys_clk_den_o === HALF_DEN, "lock start");
        count_high(0, -1, n);
        // the first locking edge passed before the count started
        chk(n + 1 == LC, "lock length");
      end
      chk(sys_clk_num_o === rows[i].num && sys_clk_den_o === rows[i].den, "ratio row");
      measure_half(n);
      chk(n == rows[i].half, "clock out row");
    end
    $display("test table done");
    issue(1, 4'h8);
    @(posedge core_clk_i);
    #1;
    count_high(0, 10, n);
    chk(n + 1 == 12 + LC, "lock restart");
    chk(sys_clk_num_o === 4'h8 && sys_clk_den_o === PLL_DEN, "ratio after restart");
    $display("test lock_restart done");
    @(negedge core_clk_i);
    wd_expire_i = 1'b1;
    @(negedge core_clk_i);
    wd_expire_i = 1'b0;
    #6;
    chk(ext_reset_n_oe_o === 1'b1 && ext_reset_n_o === 1'b0 && pin === 1'b0, "wd pin");
    count_high(1, 100, n);
    chk(n + 1 == WD_PULSE_CYC && device_reset_o === 1'b1, "watchdog pulse");
    wait_release(1'b0, 4'h0);
    $display("test watchdog done");
    @(negedge core_clk_i);
    req = 1'b1;
    strap = 4'h5;
    @(negedge core_clk_i);
    req = 1'b0;
    wait_release(1'b1, 4'h5);
    $display("test warm_reset done");
    issue(0, 4'h1);
    @(negedge core_clk_i);
    rst_n_i = 1'b0;
    req = 1'b1;
    strap = 4'h3;
    repeat (3) @(negedge core_clk_i);
    chk(sys_clk_num_o === QUARTER_NUM && bus_valid_o === 1'b0 && device_reset_o === 1'b1, "second reset");
    rst_n_i = 1'b1;
    req = 1'b0;
    wait_release(1'b1, 4'h3);
    $display("test second_reset done");
    final_report();
  end
endmodule
`default_nettype wire

// file: timer_if.sv
// load / busy / done bundle between the sequencer and a cycle timer
`timescale 1ns/1ps
`default_nettype none
interface timer_if #(parameter int W = 8);
  logic load;
  logic [W-1:0] load_val;
  logic busy;
  logic done;
  modport ctrl (output load, output load_val, input busy, input done);
  modport cnt (input load, input load_val, output busy, output done);
endinterface
`default_nettype wire
